//--- include/pae_pkg.sv
// Shared constants for the process alarm evaluator
// Operation
// - Each alarm holds its own type code
// - Reset sets every type to deviation upper
// - ON and OFF delays, 0 to 999 s
// - Aux outputs routed by output assignment
// - Heater variant: aux 1 defaults to heater
// - Type 0 disables alarm, output never turns on
// - Type 1 on outside deviation band
// - Type 2 on when PV at or above SP+X
// - Type 3 on when PV at or below SP-X
// - Type 4 on inside deviation band
// - Types 5-7 add standby to 1-3
// - Type 8 on when PV above X
// - Type 9 on when PV below X
// - Types 10, 11 add standby to 8, 9
// - Type 12 loop burnout, alarm 1 only
// - Type 13 follows PV change rate
// - Types 1, 4, 5 use separate H, L
// - Type 5 off when hysteresis regions overlap
package pae_pkg;
  // ==========================================================
  // Sizes
  localparam int N_ALARM = 3;
  localparam int N_AUX   = 3;
  localparam int DW      = 16;
  localparam int EW      = 18;
  localparam int TW      = 5;
  localparam int AW      = 3;
  localparam int DLY_W   = 10;
  localparam logic [DLY_W-1:0] DLY_MAX = 10'h3e7;
  // ==========================================================
  // Alarm type codes
  localparam logic [TW-1:0] T_OFF     = 5'h00;
  localparam logic [TW-1:0] T_DEV_UL  = 5'h01;
  localparam logic [TW-1:0] T_DEV_U   = 5'h02;
  localparam logic [TW-1:0] T_DEV_L   = 5'h03;
  localparam logic [TW-1:0] T_DEV_IN  = 5'h04;
  localparam logic [TW-1:0] T_SB_UL   = 5'h05;
  localparam logic [TW-1:0] T_SB_U    = 5'h06;
  localparam logic [TW-1:0] T_SB_L    = 5'h07;
  localparam logic [TW-1:0] T_ABS_U   = 5'h08;
  localparam logic [TW-1:0] T_ABS_L   = 5'h09;
  localparam logic [TW-1:0] T_SB_AU   = 5'h0a;
  localparam logic [TW-1:0] T_SB_AL   = 5'h0b;
  localparam logic [TW-1:0] T_LOOP    = 5'h0c;
  localparam logic [TW-1:0] T_RATE    = 5'h0d;
  localparam logic [TW-1:0] T_LAST    = 5'h0d;
  localparam logic [TW-1:0] T_RESET   = 5'h02;
  // ==========================================================
  // Output assignment codes: 0 none, 1..N_ALARM alarm k, then heater
  localparam logic [AW-1:0] A_NONE    = 3'h0;
  localparam logic [AW-1:0] A_ALARM1  = 3'h1;
  localparam logic [AW-1:0] A_HEATER  = 3'h4;
  // ==========================================================
  // Timing
  localparam int CLK_HZ      = 25000000;
  localparam int TICK_TIME_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_TIME_S;
  localparam int TICK_W      = 25;
endpackage

//--- rtl/pae_alarm_eval.sv
// Process alarm evaluator: per-alarm type logic, standby, delays, aux routing
`timescale 1ns/1ps
`default_nettype none
module pae_alarm_eval #(
  parameter int TICK_CYCLES = pae_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                                          CLK_SYS,
  input  wire logic                                          ARST_N,
  // Process inputs
  input  wire logic signed [pae_pkg::DW-1:0]                 PROCESS_VALUE,
  input  wire logic signed [pae_pkg::DW-1:0]                 SET_POINT,
  input  wire logic signed [pae_pkg::DW-1:0]                 PV_RATE,
  input  wire logic        [pae_pkg::DW-1:0]                 HYSTERESIS,
  input  wire logic                                          LOOP_BURNOUT_ALARM,
  input  wire logic                                          HEATER_ALARM,
  input  wire logic                                          HEATER_OPTION,
  input  wire logic                                          STANDBY_RESTART,
  // Per-alarm values
  input  wire logic [pae_pkg::N_ALARM-1:0][pae_pkg::DW-1:0]    ALARM_VALUE,
  input  wire logic [pae_pkg::N_ALARM-1:0][pae_pkg::DW-1:0]    ALARM_UPPER,
  input  wire logic [pae_pkg::N_ALARM-1:0][pae_pkg::DW-1:0]    ALARM_LOWER,
  input  wire logic [pae_pkg::N_ALARM-1:0][pae_pkg::DLY_W-1:0] ON_DELAY,
  input  wire logic [pae_pkg::N_ALARM-1:0][pae_pkg::DLY_W-1:0] OFF_DELAY,
  // Type selection write
  input  wire logic                                          TYPE_WE,
  input  wire logic [1:0]                                    TYPE_IDX,
  input  wire logic [pae_pkg::TW-1:0]                        TYPE_DATA,
  // Output assignment write
  input  wire logic                                          ASSIGN_WE,
  input  wire logic [1:0]                                    ASSIGN_IDX,
  input  wire logic [pae_pkg::AW-1:0]                        ASSIGN_DATA,
  // Status
  output logic [pae_pkg::N_ALARM-1:0][pae_pkg::TW-1:0]         ALARM_TYPE,
  output logic [pae_pkg::N_AUX-1:0][pae_pkg::AW-1:0]           AUX_ASSIGN,
  output logic                                               TYPE_REJECT,
  output logic                                               ASSIGN_REJECT,
  output logic                                               TYPE1_HIDDEN,
  output logic [pae_pkg::N_ALARM-1:0]                        ALARM_STATE,
  // Auxiliary outputs
  output logic [pae_pkg::N_AUX-1:0]                          AUX_OUT
);
  localparam int EW = pae_pkg::EW;

  // ==========================================================
  // Helpers
  // Hysteresis: once on, an upper alarm holds until the value drops a band below
  function automatic logic up_hit(input logic signed [EW-1:0] v, input logic signed [EW-1:0] thr,
                                  input logic signed [EW-1:0] hy, input logic st);
    up_hit = st ? (v >= thr - hy) : (v >= thr);
  endfunction
  function automatic logic lo_hit(input logic signed [EW-1:0] v, input logic signed [EW-1:0] thr,
                                  input logic signed [EW-1:0] hy, input logic st);
    lo_hit = st ? (v <= thr + hy) : (v <= thr);
  endfunction
  function automatic logic any_assign(input logic [pae_pkg::N_AUX-1:0][pae_pkg::AW-1:0] a,
                                      input logic [pae_pkg::AW-1:0] code);
    any_assign = 1'b0;
    for (int k = 0; k < pae_pkg::N_AUX; k++) begin
      if (a[k] == code) begin
        any_assign = 1'b1;
      end
    end
  endfunction
  function automatic logic is_standby(input logic [pae_pkg::TW-1:0] t);
    is_standby = (t == pae_pkg::T_SB_UL) || (t == pae_pkg::T_SB_U) || (t == pae_pkg::T_SB_L) ||
                 (t == pae_pkg::T_SB_AU) || (t == pae_pkg::T_SB_AL);
  endfunction

  // ==========================================================
  // One-second enable
  logic [pae_pkg::TICK_W-1:0] tick_cnt_r;
  logic                       tick;
  assign tick = (tick_cnt_r == pae_pkg::TICK_W'(TICK_CYCLES - 1));
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // ==========================================================
  // Output assignment and heater strap
  logic [pae_pkg::N_AUX-1:0][pae_pkg::AW-1:0] assign_r;
  logic                                      init_r;
  logic                                      heater_opt_r;
  logic                                      assign_ok;
  logic                                      hide1;
  logic                                      assign_rej_r;
  assign assign_ok = ASSIGN_WE && (ASSIGN_IDX < 2'(pae_pkg::N_AUX)) &&
                     (ASSIGN_DATA <= pae_pkg::A_HEATER);
  // Alarm 1 type is hidden while the heater variant has no output on alarm 1
  assign hide1 = heater_opt_r && !any_assign(assign_r, pae_pkg::A_ALARM1);

  // Strap is caught on the first edge after release, never under reset
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      init_r       <= 1'b0;
      heater_opt_r <= 1'b0;
    end else if (!init_r) begin
      init_r       <= 1'b1;
      heater_opt_r <= HEATER_OPTION;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      assign_rej_r <= 1'b0;
    end else begin
      assign_rej_r <= ASSIGN_WE && !assign_ok;
    end
  end

  genvar k;
  generate
    for (k = 0; k < pae_pkg::N_AUX; k++) begin : g_aux
      always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
          assign_r[k] <= pae_pkg::AW'(k + 1);
        end else if (!init_r && k == 0) begin
          assign_r[k] <= HEATER_OPTION ? pae_pkg::A_HEATER : pae_pkg::A_ALARM1;
        end else if (assign_ok && ASSIGN_IDX == 2'(k)) begin
          assign_r[k] <= ASSIGN_DATA;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Per-alarm evaluation
  logic [pae_pkg::N_ALARM-1:0][pae_pkg::TW-1:0] type_r;
  logic [pae_pkg::N_ALARM-1:0]                  raw_r;
  logic [pae_pkg::N_ALARM-1:0]                  raw_c;
  logic [pae_pkg::N_ALARM-1:0]                  standby_r;
  logic [pae_pkg::N_ALARM-1:0]                  cond;
  logic [pae_pkg::N_ALARM-1:0]                  alarm_out;
  logic [pae_pkg::N_ALARM-1:0]                  type_ok;
  logic [pae_pkg::N_ALARM-1:0]                  overlap;
  logic                                        type_rej_r;

  wire signed [EW-1:0] pv = EW'(PROCESS_VALUE);
  wire signed [EW-1:0] sp = EW'(SET_POINT);
  wire signed [EW-1:0] rt = EW'(PV_RATE);
  wire signed [EW-1:0] hy = EW'({1'b0, HYSTERESIS});

  genvar i;
  generate
    for (i = 0; i < pae_pkg::N_ALARM; i++) begin : g_alm
      wire signed [EW-1:0] x   = EW'($signed(ALARM_VALUE[i]));
      wire signed [EW-1:0] h   = EW'($signed(ALARM_UPPER[i]));
      wire signed [EW-1:0] l   = EW'($signed(ALARM_LOWER[i]));
      // Separate H and L limits for the band types
      wire signed [EW-1:0] upr = sp + h;
      wire signed [EW-1:0] lwr = sp - l;
      wire band_out = up_hit(pv, upr, hy, raw_r[i]) || lo_hit(pv, lwr, hy, raw_r[i]);
      wire band_in  = (pv >= lwr) && (pv <= upr);
      wire dev_up   = up_hit(pv, sp + x, hy, raw_r[i]);
      wire dev_lo   = lo_hit(pv, sp - x, hy, raw_r[i]);
      wire abs_up   = up_hit(pv, x + EW'(1), hy, raw_r[i]);
      wire abs_lo   = lo_hit(pv, x - EW'(1), hy, raw_r[i]);
      wire rate_up  = up_hit(rt, x, hy, raw_r[i]);
      wire loop_burnout_alarm      = (i == 0) && LOOP_BURNOUT_ALARM;

      // Band narrower than two hysteresis widths: regions overlap, so type 5 stays off
      assign overlap[i] = ((upr - lwr) < (hy <<< 1));

      always_comb begin
        unique case (type_r[i])
          pae_pkg::T_OFF:    raw_c[i] = 1'b0;
          pae_pkg::T_DEV_UL: raw_c[i] = band_out;
          pae_pkg::T_DEV_U:  raw_c[i] = dev_up;
          pae_pkg::T_DEV_L:  raw_c[i] = dev_lo;
          pae_pkg::T_DEV_IN: raw_c[i] = band_in;
          pae_pkg::T_SB_UL:  raw_c[i] = band_out;
          pae_pkg::T_SB_U:   raw_c[i] = dev_up;
          pae_pkg::T_SB_L:   raw_c[i] = dev_lo;
          pae_pkg::T_ABS_U:  raw_c[i] = abs_up;
          pae_pkg::T_ABS_L:  raw_c[i] = abs_lo;
          pae_pkg::T_SB_AU:  raw_c[i] = abs_up;
          pae_pkg::T_SB_AL:  raw_c[i] = abs_lo;
          pae_pkg::T_LOOP:   raw_c[i] = loop_burnout_alarm;
          pae_pkg::T_RATE:   raw_c[i] = rate_up;
          default:           raw_c[i] = 1'b0;
        endcase
      end

      assign cond[i] = raw_c[i] && !(is_standby(type_r[i]) && standby_r[i]) &&
                       !(type_r[i] == pae_pkg::T_SB_UL && overlap[i]);

      // Code 12 only on alarm 1; alarm 1 locked while hidden behind the heater alarm
      assign type_ok[i] = TYPE_WE && TYPE_IDX == 2'(i) && TYPE_DATA <= pae_pkg::T_LAST &&
                          !(TYPE_DATA == pae_pkg::T_LOOP && i != 0) && !(i == 0 && hide1);

      always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
          type_r[i]    <= pae_pkg::T_RESET;
          raw_r[i]     <= 1'b0;
          standby_r[i] <= 1'b1;
        end else begin
          if (type_ok[i]) begin
            type_r[i] <= TYPE_DATA;
          end
          raw_r[i] <= raw_c[i];
          // Restart arms standby; leaving the region releases it
          if (STANDBY_RESTART || type_ok[i]) begin
            standby_r[i] <= 1'b1;
          end else if (!raw_c[i]) begin
            standby_r[i] <= 1'b0;
          end
        end
      end

      pae_delay u_delay (
        .clk     (CLK_SYS),
        .arst_n  (ARST_N),
        .tick    (tick),
        .cond    (cond[i]),
        .on_dly  (ON_DELAY[i]),
        .off_dly (OFF_DELAY[i]),
        .out     (alarm_out[i])
      );

      a_type_zero_off: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        type_r[i] == pae_pkg::T_OFF && !alarm_out[i] |=> !alarm_out[i]) else $error("type 0 alarm active");
      a_standby_hold: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        is_standby(type_r[i]) && ($past(STANDBY_RESTART) || $past(type_ok[i])) |-> !cond[i])
        else $error("standby not suppressing");
      a_overlap_off: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        type_r[i] == pae_pkg::T_SB_UL && (h + l) < (hy + hy) |-> !cond[i]) else $error("overlap not off");
    end
  endgenerate

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      type_rej_r <= 1'b0;
    end else begin
      type_rej_r <= TYPE_WE && !(|type_ok);
    end
  end

  // ==========================================================
  // Aux output routing, registered
  logic [pae_pkg::N_AUX-1:0] aux_r;
  logic [pae_pkg::N_AUX-1:0] aux_nxt;
  generate
    for (k = 0; k < pae_pkg::N_AUX; k++) begin : g_route
      assign aux_nxt[k] = (assign_r[k] == pae_pkg::A_HEATER) ? HEATER_ALARM
                        : (assign_r[k] == pae_pkg::A_NONE) ? 1'b0
                        : alarm_out[2'(assign_r[k] - 3'h1)];
    end
  endgenerate
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      aux_r <= '0;
    end else begin
      aux_r <= aux_nxt;
    end
  end

  assign AUX_OUT       = aux_r;
  assign ALARM_TYPE    = type_r;
  assign AUX_ASSIGN    = assign_r;
  assign ALARM_STATE   = alarm_out;
  assign TYPE_REJECT   = type_rej_r;
  assign ASSIGN_REJECT = assign_rej_r;
  assign TYPE1_HIDDEN  = hide1;

  // ==========================================================
  // Checks
  a_lba_alarm1_only: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    TYPE_WE && TYPE_IDX != 2'h0 && TYPE_DATA == pae_pkg::T_LOOP |=> TYPE_REJECT &&
    ALARM_TYPE == $past(ALARM_TYPE)) else $error("loop burnout type taken off alarm 1");
  a_type_write: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    TYPE_WE && TYPE_IDX == 2'h1 && TYPE_DATA <= pae_pkg::T_RATE && TYPE_DATA != pae_pkg::T_LOOP
    |=> ALARM_TYPE[1] == $past(TYPE_DATA) && ALARM_TYPE[0] == $past(ALARM_TYPE[0]))
    else $error("type write not independent");
  a_aux_route: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    AUX_ASSIGN[0] == pae_pkg::A_ALARM1 && $stable(AUX_ASSIGN[0]) |-> AUX_OUT[0] == $past(ALARM_STATE[0]))
    else $error("aux not following alarm 1");
  a_hidden_locked: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    TYPE1_HIDDEN && TYPE_WE && TYPE_IDX == 2'h0 |=> TYPE_REJECT)
    else $error("hidden alarm 1 type written");
  a_tick_spacing: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    tick |=> !tick) else $error("second enable too close");

  c_type_change:  cover property (@(posedge CLK_SYS) disable iff (!ARST_N) TYPE_WE && |type_ok);
  c_aux_on:       cover property (@(posedge CLK_SYS) disable iff (!ARST_N) $rose(AUX_OUT[0]));
  c_standby_rel:  cover property (@(posedge CLK_SYS) disable iff (!ARST_N) $fell(standby_r[1]));
  c_type_reject:  cover property (@(posedge CLK_SYS) disable iff (!ARST_N) TYPE_REJECT);
endmodule
`default_nettype wire

//--- rtl/pae_delay.sv
// ON/OFF delay stage for one alarm output
`timescale 1ns/1ps
`default_nettype none
module pae_delay (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  // One-second enable
  input  wire logic                          tick,
  // Condition and delays
  input  wire logic                          cond,
  input  wire logic [pae_pkg::DLY_W-1:0]     on_dly,
  input  wire logic [pae_pkg::DLY_W-1:0]     off_dly,
  // Delayed output
  output logic                               out
);
  logic [pae_pkg::DLY_W-1:0] cnt_r;
  logic [pae_pkg::DLY_W-1:0] cnt_nxt;
  logic                      out_r;
  logic                      out_nxt;
  logic [pae_pkg::DLY_W-1:0] dly;
  wire                       differ = (cond != out_r);
  wire                       done   = (cnt_r >= dly);

  // Delays above the limit clamp, so a bad setting cannot stretch the count
  assign dly = ((cond ? on_dly : off_dly) > pae_pkg::DLY_MAX) ? pae_pkg::DLY_MAX
             : (cond ? on_dly : off_dly);
  // Any glitch back to the old level restarts the count
  assign cnt_nxt = !differ ? '0 : done ? '0 : tick ? cnt_r + 1'b1 : cnt_r;
  assign out_nxt = (differ && done) ? cond : out_r;
  assign out     = out_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_on_after_delay: assert property ($rose(out_r) |-> $past(cond) && $past(cnt_r) >= $past(on_dly > pae_pkg::DLY_MAX ? pae_pkg::DLY_MAX : on_dly)) else $error("output rose before on delay");
  a_off_after_delay: assert property ($fell(out_r) |-> !$past(cond) && $past(cnt_r) >= $past(off_dly > pae_pkg::DLY_MAX ? pae_pkg::DLY_MAX : off_dly)) else $error("output fell before off delay");
  a_count_bounded: assert property (cnt_r <= pae_pkg::DLY_MAX) else $error("delay count past limit");
  a_zero_delay: assert property (cond && !out_r && on_dly == '0 |=> out_r) else $error("zero on delay not immediate");
  c_on_delayed: cover property (cond && !out_r && on_dly != '0 ##1 cond [*3] ##1 out_r);
endmodule
`default_nettype wire

//--- verif/pae_alarm_eval_test.sv
// Self-checking bench for the process alarm evaluator
`timescale 1ns/1ps
`default_nettype none
module pae_alarm_eval_test;
  // ==========================================================
  // Signals
  localparam int TK = 4;
  logic                                              clk;
  logic                                              arst_n;
  logic signed [pae_pkg::DW-1:0]                     pv;
  logic signed [pae_pkg::DW-1:0]                     sp;
  logic signed [pae_pkg::DW-1:0]                     rate;
  logic        [pae_pkg::DW-1:0]                     hyst;
  logic                                              loop_burnout_alarm;
  logic                                              heater_alarm;
  logic                                              heater_option;
  logic                                              sb_restart;
  logic [pae_pkg::N_ALARM-1:0][pae_pkg::DW-1:0]      alarm_value;
  logic [pae_pkg::N_ALARM-1:0][pae_pkg::DW-1:0]      alarm_upper;
  logic [pae_pkg::N_ALARM-1:0][pae_pkg::DW-1:0]      alarm_lower;
  logic [pae_pkg::N_ALARM-1:0][pae_pkg::DLY_W-1:0]   on_delay;
  logic [pae_pkg::N_ALARM-1:0][pae_pkg::DLY_W-1:0]   off_delay;
  logic                                              type_we;
  logic [1:0]                                        type_idx;
  logic [pae_pkg::TW-1:0]                            type_data;
  logic                                              assign_we;
  logic [1:0]                                        assign_idx;
  logic [pae_pkg::AW-1:0]                            assign_data;
  logic [pae_pkg::N_ALARM-1:0][pae_pkg::TW-1:0]      alarm_type;
  logic [pae_pkg::N_AUX-1:0][pae_pkg::AW-1:0]        aux_assign;
  logic                                              type_reject;
  logic                                              assign_reject;
  logic                                              type1_hidden;
  logic [pae_pkg::N_ALARM-1:0]                       alarm_state;
  logic [pae_pkg::N_AUX-1:0]                         aux_out;
  int                                                num_errors = 0;
  int                                                checks_done = 0;
  int                                                cycles = 0;
  int                                                seed = 32'he5e34b56;
  // ==========================================================
  // Design under test, tick shortened to keep delays a few cycles long
  pae_alarm_eval #(.TICK_CYCLES(TK)) pae_alarm_eval_i (
    .CLK_SYS(clk), .ARST_N(arst_n), .PROCESS_VALUE(pv), .SET_POINT(sp), .PV_RATE(rate),
    .HYSTERESIS(hyst), .LOOP_BURNOUT_ALARM(loop_burnout_alarm), .HEATER_ALARM(heater_alarm),
    .HEATER_OPTION(heater_option), .STANDBY_RESTART(sb_restart), .ALARM_VALUE(alarm_value),
    .ALARM_UPPER(alarm_upper), .ALARM_LOWER(alarm_lower), .ON_DELAY(on_delay),
    .OFF_DELAY(off_delay), .TYPE_WE(type_we), .TYPE_IDX(type_idx), .TYPE_DATA(type_data),
    .ASSIGN_WE(assign_we), .ASSIGN_IDX(assign_idx), .ASSIGN_DATA(assign_data),
    .ALARM_TYPE(alarm_type), .AUX_ASSIGN(aux_assign), .TYPE_REJECT(type_reject),
    .ASSIGN_REJECT(assign_reject), .TYPE1_HIDDEN(type1_hidden), .ALARM_STATE(alarm_state),
    .AUX_OUT(aux_out));
  // ==========================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      print_verdict();
    end
  end
  // ==========================================================
  // Helpers
  task automatic print_verdict();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset(input logic heat);
    arst_n = 1'b0;
    heater_option = heat;
    cyc(6);
    arst_n = 1'b1;
    cyc(2);
  endtask
  task automatic wr_type(input int idx, input int data, input logic rej);
    type_we = 1'b1;
    type_idx = 2'(idx);
    type_data = 5'(data);
    cyc(1);
    type_we = 1'b0;
    chk(type_reject, rej);
    cyc(1);
  endtask
  task automatic wr_assign(input int idx, input int data, input logic rej);
    assign_we = 1'b1;
    assign_idx = 2'(idx);
    assign_data = 3'(data);
    cyc(1);
    assign_we = 1'b0;
    chk(assign_reject, rej);
    cyc(1);
  endtask
  // Negedges until alarm 3 reaches the wanted level, bounded
  task automatic wait_lvl(input logic want, output int n);
    n = 0;
    while (alarm_state[2] !== want && n < 40) begin
      cyc(1);
      n++;
    end
  endtask
  function automatic logic exp_cond(input int t, input int p, input int s, input int x,
                                    input int h, input int l, input int r);
    case (t)
      1: return (p >= s + h) || (p <= s - l);
      2: return p >= s + x;
      3: return p <= s - x;
      4: return (p >= s - l) && (p <= s + h);
      8: return p > x;
      9: return p < x;
      13: return r >= x;
      default: return 1'b0;
    endcase
  endfunction
  // ==========================================================
  // Main sequence
  initial begin : main
    int codes [8] = '{0, 1, 2, 3, 4, 8, 9, 13};
    int t, n, last;
    int pr;
    int sb_codes [4] = '{6, 11, 7, 10};
    logic signed [pae_pkg::DW-1:0] on_v;
    logic signed [pae_pkg::DW-1:0] off_v;
    logic e;
    {pv, sp, rate, hyst, loop_burnout_alarm, heater_alarm, sb_restart} = '0;
    {type_we, type_idx, type_data, assign_we, assign_idx, assign_data} = '0;
    alarm_value = '0;
    alarm_upper = '0;
    alarm_lower = '0;
    on_delay = '0;
    off_delay = '0;
    alarm_value[2] = 16'h0064;
    do_reset(1'b0);
    for (int k = 0; k < 3; k++) begin
      chk(alarm_type[k], 2);
      chk(aux_assign[k], k + 1);
    end
    $display("reset defaults done");
    last = 2;
    for (int c = 0; c < 16; c++) begin
      wr_type(2, c, c > 13 || c == 12);
      if (!(c > 13 || c == 12)) last = c;
      chk(alarm_type[2], last);
      chk(alarm_type[0], 2);
    end
    wr_type(3, 1, 1'b1);
    $display("type writes done");
    for (int i = 0; i < 60; i++) begin
      t = codes[$unsigned($random(seed)) % 8];
      sp = 16'($random(seed) % 400);
      pr = $random(seed) % 600;
      rate = 16'($random(seed) % 50);
      alarm_value[1] = 16'($random(seed) % 300);
      alarm_upper[1] = 16'($random(seed) % 200);
      alarm_lower[1] = 16'($random(seed) % 200);
      pv = (i % 6 == 0) ? sp + $signed(alarm_value[1]) : 16'(pr);
      wr_type(1, t, 1'b0);
      cyc(3);
      e = exp_cond(t, pv, sp, $signed(alarm_value[1]), $signed(alarm_upper[1]),
                   $signed(alarm_lower[1]), rate);
      chk(alarm_state[1], e);
      chk(aux_out[1], e);
    end
    $display("random conditions done");
    sp = '0;
    alarm_value[0] = 16'h0032;
    for (int s = 0; s < 4; s++) begin
      on_v = (s == 1) ? 16'sd0 : (s == 2) ? -16'sd100 : 16'sd100;
      off_v = (s == 1) ? 16'sd100 : 16'sd0;
      pv = on_v;
      wr_type(0, sb_codes[s], 1'b0);
      cyc(3);
      chk(alarm_state[0], 1'b0);
      pv = off_v;
      cyc(3);
      pv = on_v;
      cyc(3);
      chk(alarm_state[0], 1'b1);
      sb_restart = 1'b1;
      cyc(1);
      sb_restart = 1'b0;
      cyc(3);
      chk(alarm_state[0], 1'b0);
    end
    hyst = 16'h0006;
    for (int s = 0; s < 2; s++) begin
      alarm_upper[1] = (s == 0) ? 16'h0005 : 16'h0032;
      alarm_lower[1] = alarm_upper[1];
      pv = '0;
      wr_type(1, 5, 1'b0);
      cyc(3);
      pv = 16'sd100;
      cyc(3);
      chk(alarm_state[1], s == 1);
    end
    hyst = '0;
    $display("standby done");
    wr_type(2, 8, 1'b0);
    on_delay[2] = 10'h003;
    off_delay[2] = 10'h002;
    pv = '0;
    cyc(12);
    pv = 16'sd200;
    wait_lvl(1'b1, n);
    chk(n >= 2 * TK && n <= 3 * TK + 1, 1'b1);
    cyc(1);
    chk(aux_out[2], 1'b1);
    pv = '0;
    wait_lvl(1'b0, n);
    chk(n >= TK && n <= 2 * TK + 1, 1'b1);
    pv = 16'sd200;
    cyc(6);
    pv = '0;
    cyc(1);
    pv = 16'sd200;
    wait_lvl(1'b1, n);
    chk(n >= 2 * TK && n <= 3 * TK + 1, 1'b1);
    pv = '0;
    $display("delays done");
    wr_type(0, 12, 1'b0);
    loop_burnout_alarm = 1'b1;
    cyc(3);
    chk(alarm_state[0], 1'b1);
    loop_burnout_alarm = 1'b0;
    cyc(3);
    chk(alarm_state[0], 1'b0);
    do_reset(1'b1);
    chk(aux_assign[0], 4);
    chk(type1_hidden, 1'b1);
    wr_type(0, 3, 1'b1);
    heater_alarm = 1'b1;
    cyc(3);
    chk(aux_out[0], 1'b1);
    wr_assign(2, 5, 1'b1);
    wr_assign(3, 1, 1'b1);
    wr_assign(1, 1, 1'b0);
    chk(aux_assign[1], 1);
    chk(type1_hidden, 1'b0);
    wr_type(0, 3, 1'b0);
    chk(alarm_type[0], 3);
    $display("heater variant done");
    print_verdict();
  end
endmodule
`default_nettype wire
